// ### hdl/qdr_cfg.svh
// timing, field and framing constants for the readback link
`ifndef QDR_CFG_SVH
`define QDR_CFG_SVH
`define QDR_ADDR_FIXED    5'h13
`define QDR_CTRL_PD       0
`define QDR_CTRL_SEL_LO   1
`define QDR_CTRL_SEL_HI   2
`define QDR_PD_FILL       6'h3F
`define QDR_LOW_FILL      6'h00
`define QDR_REG_RST       12'h000
`define QDR_CTRL_RST      8'h00
`define QDR_BIT_LAST      4'h8
`define QDR_CLK_NS        8
`define QDR_SCL_PERIOD_NS 2500
`define QDR_QUARTER_CYC   ((`QDR_SCL_PERIOD_NS / 4) / `QDR_CLK_NS)
`endif

// ### hdl/qdr_if.sv
// two-wire link joining master and device, open-drain resolution
`timescale 1ns/1ps
interface qdr_if;
  logic scl_m_out;
  logic scl_m_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = !(scl_m_oe && !scl_m_out);
  assign sda = !(sda_m_oe && !sda_m_out) && !(sda_s_oe && !sda_s_out);
  modport master (output scl_m_out, scl_m_oe, sda_m_out, sda_m_oe,
                  input  scl, sda);
  modport slave  (output sda_s_out, sda_s_oe, input scl, sda);
endinterface // qdr_if

// ### hdl/qdr_master.sv
// master end: write address, control byte, repeated start, readback
`include "qdr_cfg.svh"
`timescale 1ns/1ps
module qdr_master (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  qdr_if.master            bus,
  input  wire logic        go,
  input  wire logic [1:0]  dev_addr,
  input  wire logic [7:0]  ctrl_in,
  output logic             busy,
  output logic             done,
  output logic             ack_err,
  output logic [23:0]      rd_data
);
  localparam int QC = `QDR_QUARTER_CYC;
  qdr_pkg::qdr_mst_state_t state, next_state;
  logic [7:0]  tick, next_tick;
  logic [1:0]  q, next_q;
  logic [3:0]  bitn, next_bitn;
  logic [2:0]  step, next_step;
  logic [7:0]  sh, next_sh;
  logic [7:0]  ctrl, next_ctrl;
  logic [1:0]  nrd, next_nrd;
  logic [23:0] next_rd_data;
  logic        scl_oe, next_scl_oe, sda_oe, next_sda_oe;
  logic        next_busy, next_done, next_ack_err;
  logic [2:0]  sda_sync;
  logic        sda_f;
  logic        qt;
  logic        last_rd;

  assign qt      = (tick == 8'(QC - 1));
  assign last_rd = (nrd == 2'h1);

  always_comb begin
    next_state = state;  next_tick = qt ? 8'h00 : tick + 8'h01;
    next_q = q;  next_bitn = bitn;  next_step = step;  next_sh = sh;
    next_ctrl = ctrl;  next_nrd = nrd;  next_rd_data = rd_data;
    next_scl_oe = scl_oe;  next_sda_oe = sda_oe;
    next_busy = busy;  next_done = 1'b0;  next_ack_err = ack_err;
    if (state == qdr_pkg::MS_IDLE) begin
      next_tick = 8'h00;
      if (go) begin
        next_state = qdr_pkg::MS_START;  next_step = 3'h0;
        next_ctrl = ctrl_in;  next_busy = 1'b1;  next_ack_err = 1'b0;
        next_q = 2'h0;
      end
    end else if (qt) begin
      next_q = q + 2'h1;
      unique case (state)
        qdr_pkg::MS_START: unique case (q)
          2'h0: next_sda_oe = 1'b0;
          2'h1: next_scl_oe = 1'b0;
          2'h2: next_sda_oe = 1'b1;
          default: begin
            next_scl_oe = 1'b1;  next_state = qdr_pkg::MS_WBYTE;
            next_bitn = 4'h0;    next_step = step + 3'h1;
            next_sh = {`QDR_ADDR_FIXED, dev_addr, step != 3'h0};
          end
        endcase
        qdr_pkg::MS_STOP: unique case (q)
          2'h0: next_sda_oe = 1'b1;
          2'h1: next_scl_oe = 1'b0;
          2'h2: next_sda_oe = 1'b0;
          default: begin
            next_state = qdr_pkg::MS_IDLE;
            next_busy = 1'b0;  next_done = 1'b1;
          end
        endcase
        default: unique case (q)
          2'h0: next_sda_oe = (state == qdr_pkg::MS_WBYTE)
                  ? (bitn != `QDR_BIT_LAST && !sh[7])
                  : (bitn == `QDR_BIT_LAST && !last_rd);
          2'h1: next_scl_oe = 1'b0;
          2'h2: if (bitn == `QDR_BIT_LAST) begin
            if (state == qdr_pkg::MS_WBYTE && sda_f)
              next_ack_err = 1'b1;
          end else if (state == qdr_pkg::MS_RBYTE)
            next_rd_data = {rd_data[22:0], sda_f};
          default: begin
            next_scl_oe = 1'b1;
            next_sh = {sh[6:0], 1'b0};
            next_bitn = bitn + 4'h1;
            // let go of data with the clock low so the device can ack
            // or shift without both ends pulling the line at once
            if (bitn == 4'h7 || bitn == `QDR_BIT_LAST)
              next_sda_oe = 1'b0;
            if (bitn == `QDR_BIT_LAST) begin
              next_bitn = 4'h0;
              if (ack_err || (state == qdr_pkg::MS_RBYTE && last_rd))
                next_state = qdr_pkg::MS_STOP;
              else if (state == qdr_pkg::MS_RBYTE)
                next_nrd = nrd - 2'h1;
              else if (step == 3'h1) begin
                next_sh = ctrl;  next_step = 3'h2;
              end else if (step == 3'h2)
                next_state = qdr_pkg::MS_START;
              else begin
                next_state = qdr_pkg::MS_RBYTE;
                next_nrd = ctrl[`QDR_CTRL_PD] ? 2'h3 : 2'h2;
                next_rd_data = 24'h000000;
              end
            end
          end
        endcase
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= qdr_pkg::MS_IDLE;  tick <= 8'h00;  q <= 2'h0;
      bitn <= 4'h0;  step <= 3'h0;  sh <= 8'h00;  ctrl <= 8'h00;
      nrd <= 2'h0;  rd_data <= 24'h000000;  scl_oe <= 1'b0;
      sda_oe <= 1'b0;  busy <= 1'b0;  done <= 1'b0;  ack_err <= 1'b0;
      sda_sync <= 3'h7;  sda_f <= 1'b1;
      bus.scl_m_out <= 1'b0;  bus.sda_m_out <= 1'b0;
    end else begin
      state <= next_state;  tick <= next_tick;  q <= next_q;
      bitn <= next_bitn;  step <= next_step;  sh <= next_sh;
      ctrl <= next_ctrl;  nrd <= next_nrd;  rd_data <= next_rd_data;
      scl_oe <= next_scl_oe;  sda_oe <= next_sda_oe;
      busy <= next_busy;  done <= next_done;  ack_err <= next_ack_err;
      sda_sync <= {sda_sync[1:0], bus.sda};
      // line level changes only once two late stages agree
      if (sda_sync[1] == sda_sync[2])
        sda_f <= sda_sync[2];
      bus.scl_m_out <= 1'b0;  bus.sda_m_out <= 1'b0;
    end
  end

  assign bus.scl_m_oe = scl_oe;
  assign bus.sda_m_oe = sda_oe;
endmodule // qdr_master

// ### hdl/qdr_pkg.sv
// types shared by both ends of the readback link
package qdr_pkg;
  typedef enum logic [3:0] {
    SL_IDLE, SL_RX_ADDR, SL_ACK_W, SL_ACK_R, SL_RX_CTRL, SL_ACK_C,
    SL_HOLD, SL_TX, SL_MACK, SL_TX_NEXT
  } qdr_slv_state_t;
  typedef enum logic [2:0] {
    MS_IDLE, MS_START, MS_WBYTE, MS_RBYTE, MS_STOP
  } qdr_mst_state_t;
  typedef enum logic [1:0] {
    PD_HIZ_A, PD_1K, PD_100K, PD_HIZ_B
  } qdr_pd_mode_t;
endpackage

// ### hdl/qdr_slave.sv
// device end: address match, control byte decode, channel readback
// Operation
// - ack matching write address, fixed 10011 prefix
// - master sends control byte; device acks it
// - control byte: ext addr, load, x, select, flag
// - master repeated start, re-address with read
// - ack read address, then drive data line
// - latest select bits choose readback channel
// - flag clear: high byte then low byte
// - flag set: status, high, low bytes
// - high byte carries data bits nine to two
// - low byte top bits carry data one, zero
// - status byte: mode bits, then six ones
// - master acks all but final byte
// - master ends with stop or repeated start
// - mode codes: hiz, 1k, 100k, hiz
// - per channel 12-bit temporary and output registers
`include "qdr_cfg.svh"
`timescale 1ns/1ps
module qdr_slave (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  qdr_if.slave                       bus,
  input  wire logic [1:0]            addr_pin,
  input  wire logic                  load_en,
  input  wire logic [1:0]            load_chan,
  input  wire logic [11:0]           load_word,
  input  wire logic                  update_en,
  output logic      [7:0]            ctrl_byte,
  output qdr_pkg::qdr_pd_mode_t      sel_pd_mode,
  output logic                       rd_active
);
  // readback byte picker, idx counts bytes sent in this read
  function automatic logic [7:0] qdr_rb_byte(input logic [1:0]  idx,
                                            input logic        pd,
                                            input logic [11:0] w);
    logic [1:0] k;
    k = pd ? idx : idx + 2'h1;
    unique case (k)
      2'h0:    qdr_rb_byte = {w[11:10], `QDR_PD_FILL};
      2'h1:    qdr_rb_byte = w[9:2];
      default: qdr_rb_byte = {w[1:0], `QDR_LOW_FILL};
    endcase
  endfunction

  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic       scl_f;
  logic       sda_f;
  logic       scl_fq;
  logic       sda_fq;
  logic       next_scl_f;
  logic       next_sda_f;

  // pin filter: level moves only when the last two stages agree
  always_comb begin
    next_scl_f = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
    next_sda_f = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_fq   <= 1'b1;
      sda_fq   <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], bus.scl};
      sda_sync <= {sda_sync[1:0], bus.sda};
      scl_f    <= next_scl_f;
      sda_f    <= next_sda_f;
      scl_fq   <= scl_f;
      sda_fq   <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_f && !scl_fq;
  assign scl_fall = !scl_f && scl_fq;
  // start/stop seen only while the clock is steady high
  assign start_ev = scl_f && scl_fq && sda_fq && !sda_f;
  assign stop_ev  = scl_f && scl_fq && !sda_fq && sda_f;

  logic [11:0] temp_reg [4];
  logic [11:0] out_reg  [4];
  logic [11:0] next_temp_reg [4];
  logic [11:0] next_out_reg  [4];

  // channel storage; double buffered so all channels can move at once
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_temp_reg[i] = temp_reg[i];
      next_out_reg[i]  = out_reg[i];
      if (load_en && load_chan == i[1:0])
        next_temp_reg[i] = load_word;
      if (update_en)
        next_out_reg[i] = next_temp_reg[i];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        temp_reg[i] <= `QDR_REG_RST;
        out_reg[i]  <= `QDR_REG_RST;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        temp_reg[i] <= next_temp_reg[i];
        out_reg[i]  <= next_out_reg[i];
      end
    end
  end

  qdr_pkg::qdr_slv_state_t state;
  qdr_pkg::qdr_slv_state_t next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [7:0]  sh;
  logic [7:0]  next_sh;
  logic [1:0]  idx;
  logic [1:0]  next_idx;
  logic [7:0]  next_ctrl_byte;
  logic        sda_oe;
  logic        next_sda_oe;
  logic        next_rd_active;
  qdr_pkg::qdr_pd_mode_t next_sel_pd_mode;
  logic [11:0] sel_word;
  logic        addr_hit;
  logic        last_byte;

  assign sel_word = out_reg[{ctrl_byte[`QDR_CTRL_SEL_HI],
                             ctrl_byte[`QDR_CTRL_SEL_LO]}];
  assign addr_hit = (sh[7:1] == {`QDR_ADDR_FIXED, addr_pin});
  assign last_byte = (idx == (ctrl_byte[`QDR_CTRL_PD] ? 2'h2 : 2'h1));

  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_sh          = sh;
    next_idx         = idx;
    next_ctrl_byte   = ctrl_byte;
    next_sda_oe      = sda_oe;
    next_rd_active   = (state == qdr_pkg::SL_TX)
                       || (state == qdr_pkg::SL_MACK)
                       || (state == qdr_pkg::SL_TX_NEXT)
                       || (state == qdr_pkg::SL_ACK_R);
    next_sel_pd_mode = qdr_pkg::qdr_pd_mode_t'(sel_word[11:10]);
    if (stop_ev) begin
      next_state  = qdr_pkg::SL_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_ev) begin
      next_state  = qdr_pkg::SL_RX_ADDR;
      next_cnt    = 4'h0;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        qdr_pkg::SL_IDLE, qdr_pkg::SL_HOLD: ;
        qdr_pkg::SL_RX_ADDR, qdr_pkg::SL_RX_CTRL: begin
          if (scl_rise && cnt != `QDR_BIT_LAST) begin
            next_sh  = {sh[6:0], sda_f};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == `QDR_BIT_LAST) begin
            next_cnt = 4'h0;
            if (state == qdr_pkg::SL_RX_CTRL) begin
              next_ctrl_byte = sh;
              next_sda_oe    = 1'b1;
              next_state     = qdr_pkg::SL_ACK_C;
            end else if (addr_hit) begin
              next_sda_oe = 1'b1;
              next_state  = sh[0] ? qdr_pkg::SL_ACK_R
                                  : qdr_pkg::SL_ACK_W;
            end else begin
              next_state = qdr_pkg::SL_IDLE;
            end
          end
        end
        qdr_pkg::SL_ACK_W: if (scl_fall) begin
          next_sda_oe = 1'b0;
          next_state  = qdr_pkg::SL_RX_CTRL;
        end
        qdr_pkg::SL_ACK_C: if (scl_fall) begin
          // a later repeated start reopens addressing
          next_sda_oe = 1'b0;
          next_state  = qdr_pkg::SL_HOLD;
        end
        qdr_pkg::SL_ACK_R, qdr_pkg::SL_TX_NEXT: if (scl_fall) begin
          next_idx    = (state == qdr_pkg::SL_ACK_R) ? 2'h0 : idx + 2'h1;
          next_sh     = qdr_rb_byte(next_idx, ctrl_byte[`QDR_CTRL_PD],
                                    sel_word);
          next_sda_oe = !next_sh[7];
          next_cnt    = 4'h0;
          next_state  = qdr_pkg::SL_TX;
        end
        qdr_pkg::SL_TX: begin
          if (scl_rise)
            next_cnt = cnt + 4'h1;
          else if (scl_fall && cnt == `QDR_BIT_LAST) begin
            next_sda_oe = 1'b0;
            next_state  = qdr_pkg::SL_MACK;
          end else if (scl_fall) begin
            next_sh     = {sh[6:0], 1'b0};
            next_sda_oe = !sh[6];
          end
        end
        qdr_pkg::SL_MACK: if (scl_rise) begin
          // nack or the last byte ends the read with sda released
          if (!sda_f && !last_byte)
            next_state = qdr_pkg::SL_TX_NEXT;
          else
            next_state = qdr_pkg::SL_IDLE;
        end
        default: next_state = qdr_pkg::SL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state         <= qdr_pkg::SL_IDLE;
      cnt           <= 4'h0;
      sh            <= 8'h00;
      idx           <= 2'h0;
      ctrl_byte     <= `QDR_CTRL_RST;
      sda_oe        <= 1'b0;
      rd_active     <= 1'b0;
      sel_pd_mode   <= qdr_pkg::PD_HIZ_A;
      bus.sda_s_out <= 1'b0;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      sh            <= next_sh;
      idx           <= next_idx;
      ctrl_byte     <= next_ctrl_byte;
      sda_oe        <= next_sda_oe;
      rd_active     <= next_rd_active;
      sel_pd_mode   <= next_sel_pd_mode;
      bus.sda_s_out <= 1'b0;
    end
  end

  // open drain: only ever pulls low
  assign bus.sda_s_oe = sda_oe;
endmodule // qdr_slave

// ### verif/qdr_link_checker.sv
// concurrent checks on the two-wire link between master and device
`include "qdr_cfg.svh"
`timescale 1ns/1ps
module qdr_link_checker #(
  parameter logic [1:0] ADDR_PIN = 2'h0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_m_out,
  input wire logic scl_m_oe,
  input wire logic sda_m_out,
  input wire logic sda_m_oe,
  input wire logic sda_s_out,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_n;
  logic [2:0] byte_n;
  logic [7:0] shf;
  logic       adr_ok;
  logic       rd_mode;
  logic       pd_f;
  wire        scl_rise = scl && !scl_q;
  wire        start_c  = scl && scl_q && sda_q && !sda;
  wire        adr_hit  = shf[7:1] == {`QDR_ADDR_FIXED, ADDR_PIN};
  wire  [2:0] last_n   = pd_f ? 3'h3 : 3'h2;
  wire        in_read  = adr_ok && rd_mode;
  // bit counter restarts on every start, so a repeated start realigns it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      bit_n   <= 4'h0;
      byte_n  <= 3'h0;
      shf     <= 8'h00;
      adr_ok  <= 1'b0;
      rd_mode <= 1'b0;
      pd_f    <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_c) begin
        bit_n  <= 4'h0;
        byte_n <= 3'h0;
      end else if (scl_rise) begin
        shf   <= {shf[6:0], sda};
        bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
        if (bit_n == 4'h8) begin
          byte_n <= (byte_n == 3'h7) ? byte_n : byte_n + 3'h1;
          if (byte_n == 3'h0) begin
            adr_ok  <= adr_hit;
            rd_mode <= shf[0];
          end
          if (byte_n == 3'h1 && adr_ok && !rd_mode) begin
            pd_f <= shf[0];
          end
        end
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence ninth_rise;
    scl_rise && bit_n == 4'h8;
  endsequence
  sequence addr_done;
    ninth_rise ##0 (byte_n == 3'h0 && adr_hit);
  endsequence
  chk_write_addr_ack: assert property (addr_done ##0 !shf[0] |-> !sda)
    else $error("write address not acknowledged");
  chk_ctrl_ack: assert property (ninth_rise ##0
    (byte_n == 3'h1 && adr_ok && !rd_mode) |-> !sda)
    else $error("control byte not acknowledged");
  chk_read_addr_ack: assert property (addr_done ##0 shf[0] |-> !sda)
    else $error("read address not acknowledged");
  chk_miss_nack: assert property (ninth_rise ##0
    (byte_n == 3'h0 && !adr_hit) |-> sda)
    else $error("foreign address acknowledged");
  chk_miss_line_quiet: assert property (byte_n != 3'h0 && !adr_ok
    |-> !sda_s_oe) else $error("device drives after foreign address");
  chk_status_ones: assert property (scl_rise && in_read && pd_f
    && byte_n == 3'h1 && bit_n inside {[4'h2:4'h7]} |-> sda)
    else $error("status byte fill not ones");
  chk_low_zeros: assert property (scl_rise && in_read
    && byte_n == last_n && bit_n inside {[4'h2:4'h7]} |-> !sda)
    else $error("low byte fill not zero");
  chk_release_end: assert property (in_read && byte_n > last_n
    |-> !sda_s_oe) else $error("device drives past last byte");
  chk_edge_clock_low: assert property ($rose(sda_s_oe) ||
    $fell(sda_s_oe) |-> !scl) else $error("device data moved with clock high");
  chk_no_fight: assert property (!(sda_s_oe && sda_m_oe))
    else $error("both ends drive the data line");
endmodule // qdr_link_checker

// ### verif/test_quad_dac_i2c_readback.sv
// self-checking bench: master and device facing across the link
`timescale 1ns/1ps
module test_quad_dac_i2c_readback;
  localparam logic [1:0] ADDR_PIN = 2'h2;
  logic                  clk_sys = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  go, load_en, update_en, done, busy, ack_err;
  logic                  rd_active, rd_seen;
  logic [1:0]            dev_addr, load_chan;
  logic [7:0]            ctrl_in, ctrl_byte;
  logic [11:0]           load_word;
  logic [23:0]           rd_data;
  qdr_pkg::qdr_pd_mode_t sel_pd_mode;
  int                    fail_count = 0;
  int                    check_count = 0;
  logic [11:0]           w [4] = '{12'h0F0, 12'h6A5, 12'h95A, 12'hFC3};
  qdr_if link ();
  qdr_master qdr_master_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(link),
    .go(go), .dev_addr(dev_addr), .ctrl_in(ctrl_in), .busy(busy),
    .done(done), .ack_err(ack_err), .rd_data(rd_data));
  qdr_slave qdr_slave_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(link),
    .addr_pin(ADDR_PIN), .load_en(load_en), .load_chan(load_chan),
    .load_word(load_word), .update_en(update_en), .ctrl_byte(ctrl_byte),
    .sel_pd_mode(sel_pd_mode), .rd_active(rd_active));
  qdr_link_checker #(.ADDR_PIN(ADDR_PIN)) qdr_link_checker_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_m_out(link.scl_m_out),
    .scl_m_oe(link.scl_m_oe), .sda_m_out(link.sda_m_out),
    .sda_m_oe(link.sda_m_oe), .sda_s_out(link.sda_s_out),
    .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
  always #4 clk_sys = ~clk_sys;
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic load(input logic [1:0] ch, input logic [11:0] word);
    @(posedge clk_sys);
    load_en   <= 1'b1;
    load_chan <= ch;
    load_word <= word;
    @(posedge clk_sys);
    load_en <= 1'b0;
  endtask
  // one whole read; the link runs slow, so the bound is generous
  task automatic run(input logic [1:0] dev, input logic [7:0] ctrl);
    int n;
    rd_seen = 1'b0;
    @(posedge clk_sys);
    go       <= 1'b1;
    dev_addr <= dev;
    ctrl_in  <= ctrl;
    @(posedge clk_sys);
    go <= 1'b0;
    for (n = 0; n < 40000; n++) begin
      @(posedge clk_sys);
      #1;
      if (rd_active === 1'b1) rd_seen = 1'b1;
      if (done === 1'b1) break;
    end
    if (n == 40000) begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic s_reset_values;
    chk({14'h0, ctrl_byte, sel_pd_mode}, 24'h0);
    chk({20'h0, busy, done, ack_err, rd_active}, 24'h0);
    chk(rd_data, 24'h0);
  endtask
  // temp write after update must not reach readback
  task automatic s_two_byte;
    for (int c = 0; c < 4; c++) load(c[1:0], w[c]);
    @(posedge clk_sys);
    update_en <= 1'b1;
    @(posedge clk_sys);
    update_en <= 1'b0;
    load(2'h2, 12'h333);
    run(ADDR_PIN, 8'h04);
    chk({8'h0, rd_data[15:0]}, {8'h0, w[2][9:2], w[2][1:0], 6'h00});
    chk({23'h0, ack_err}, 24'h0);
    chk({16'h0, ctrl_byte}, 24'h04);
    chk({22'h0, sel_pd_mode}, {22'h0, qdr_pkg::PD_100K});
    chk({23'h0, rd_seen}, 24'h1);
  endtask
  task automatic s_three_byte(input logic [1:0] ch, input logic [7:0] ctrl,
                              input qdr_pkg::qdr_pd_mode_t mode);
    run(ADDR_PIN, ctrl);
    chk(rd_data, {w[ch][11:10], 6'h3F, w[ch][9:2], w[ch][1:0], 6'h00});
    chk({22'h0, sel_pd_mode}, {22'h0, mode});
    chk({16'h0, ctrl_byte}, {16'h0, ctrl});
    chk({23'h0, ack_err}, 24'h0);
  endtask
  // foreign address: no ack, no control update, no read phase
  task automatic s_addr_miss;
    run(~ADDR_PIN, 8'h05);
    chk({23'h0, ack_err}, 24'h1);
    chk({23'h0, rd_seen}, 24'h0);
    chk({16'h0, ctrl_byte}, 24'hC3);
    chk({22'h0, sel_pd_mode}, {22'h0, qdr_pkg::PD_1K});
  endtask
  initial begin
    go        = 1'b0;
    load_en   = 1'b0;
    update_en = 1'b0;
    dev_addr  = 2'h0;
    load_chan = 2'h0;
    load_word = 12'h000;
    ctrl_in   = 8'h00;
    rd_seen   = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    s_reset_values();
    s_two_byte();
    s_three_byte(2'h1, 8'hC3, qdr_pkg::PD_1K);
    s_addr_miss();
    s_three_byte(2'h3, 8'h07, qdr_pkg::PD_HIZ_B);
    finish_test();
  end
endmodule // test_quad_dac_i2c_readback
